// ===== include/dio_pkg.sv
// Package for the digital I/O port controller: register map, field
// positions, reset values and the packed state carried by the design.
// Assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address.
package dio_pkg;

  // ============================================================
  // Widths
  localparam int DIO_ADDR_W = 8;
  localparam int DIO_DATA_W = 32;
  localparam int DIO_IN_W = 6;
  localparam int DIO_OUT_W = 8;
  localparam int DIO_IRQ_W = 2;
  localparam int DIO_CFG_W = 16;

  // ============================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] DIO_OFS_IN_STATUS = 8'h00;
  localparam logic [7:0] DIO_OFS_OUT_DRIVE = 8'h04;
  localparam logic [7:0] DIO_OFS_OUT_CFG = 8'h08;
  localparam logic [7:0] DIO_OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] DIO_OFS_IRQ_MASK = 8'h10;

  // ============================================================
  // Field positions
  localparam int DIO_HALT_BIT = 8;
  localparam int DIO_INV_BIT = 5;
  localparam int DIO_TRIG_LSB = 8;
  localparam int DIO_IRQ_HALT = 0;
  localparam int DIO_IRQ_TRIG = 1;
  localparam int DIO_LANE_W = 8;
  localparam logic [15:0] DIO_CFG_WMASK = 16'hff20;

  // ============================================================
  // Responses and reset values
  localparam logic [1:0] DIO_RESP_OKAY = 2'h0;
  localparam logic [1:0] DIO_RESP_SLVERR = 2'h2;
  localparam logic [7:0] DIO_DRIVE_RST = 8'h00;
  localparam logic [15:0] DIO_CFG_RST = 16'h0000;
  localparam logic [1:0] DIO_IRQ_RST = 2'h0;

  // ============================================================
  // Carriers
  typedef struct packed {
    logic [DIO_IN_W-1:0] pins;
    logic halt_n;
  } dio_pin_in_t;

  localparam dio_pin_in_t DIO_PIN_IDLE = '{pins: 6'h00, halt_n: 1'b1};

  typedef struct packed {
    dio_pin_in_t meta;
    dio_pin_in_t sync;
  } dio_sync_t;

  typedef struct packed {
    logic aw_held;
    logic w_held;
    logic [DIO_ADDR_W-1:0] awaddr;
    logic [DIO_DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [DIO_DATA_W-1:0] rdata;
    logic halt;
    logic [DIO_OUT_W-1:0] drive;
    logic [DIO_CFG_W-1:0] cfg;
    logic [DIO_IRQ_W-1:0] irq_stat;
    logic [DIO_IRQ_W-1:0] irq_mask;
    logic [DIO_OUT_W-1:0] oe_n;
    logic [DIO_OUT_W-1:0] pin_level;
    logic irq;
  } dio_state_t;

  localparam dio_state_t DIO_STATE_RST = '{oe_n: {DIO_OUT_W{1'b1}}, default: '0};

endpackage : dio_pkg

// ===== hdl/dio_in_sync.sv
// Two-stage synchroniser for the input port pins and the halt pin.
// Assumes pins are asynchronous to aclk; halt pin idles high.
`timescale 1ns/1ps
`default_nettype none
module dio_in_sync
  import dio_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire dio_pin_in_t pins_raw,
  output dio_pin_in_t pins_sync
);

  // ============================================================
  // State
  dio_sync_t q;
  dio_sync_t next_q;

  always_comb begin
    next_q = q;
    next_q.meta = pins_raw;
    next_q.sync = q.meta;
  end

  // Idle value keeps the halt latch quiet through reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '{meta: DIO_PIN_IDLE, sync: DIO_PIN_IDLE};
    end else begin
      q <= next_q;
    end
  end

  assign pins_sync = q.sync;

endmodule : dio_in_sync
`default_nettype wire

// ===== hdl/dio_port_ctrl.sv
// Digital I/O port controller: six-bit input port, eight open-drain
// outputs with polarity inversion, trigger outputs and a halt latch.
// Assumes an AXI4-Lite master on aclk; pins are asynchronous.
//
// Functional notes
// R1: Input pins 5..0 readable, read-only status bits
// R2: Normal polarity: drive one turns transistor on
// R3: Normal polarity: drive zero turns transistor off
// R4: Trigger output rests off, on during trigger
// R5: Config bit 5 inverts output sense
// R6: Halt forces outputs off, on if inverted
// R7: Low halt pin sets latch until cleared
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dio_port_ctrl
  import dio_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [DIO_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DIO_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [DIO_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DIO_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [DIO_IN_W-1:0] in_pins,
  input wire logic halt_pin_n,
  input wire logic trig_event,
  output logic [DIO_OUT_W-1:0] out_pin_o,
  output logic [DIO_OUT_W-1:0] out_pin_oe_n,
  output logic irq
);

  // ============================================================
  // Decode helpers
  function automatic logic is_mapped(input logic [DIO_ADDR_W-1:0] a);
    is_mapped = (a == DIO_OFS_IN_STATUS) || (a == DIO_OFS_OUT_DRIVE) ||
                (a == DIO_OFS_OUT_CFG) || (a == DIO_OFS_IRQ_STAT) ||
                (a == DIO_OFS_IRQ_MASK);
  endfunction : is_mapped

  function automatic logic [DIO_DATA_W-1:0] merge(
    input logic [DIO_DATA_W-1:0] old_v,
    input logic [DIO_DATA_W-1:0] new_v,
    input logic [3:0] strb
  );
    logic [DIO_DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*DIO_LANE_W +: DIO_LANE_W] = {DIO_LANE_W{strb[i]}};
    end
    merge = (old_v & ~m) | (new_v & m);
  endfunction : merge

  function automatic logic [DIO_OUT_W-1:0] mosfets(
    input logic halt,
    input logic [DIO_OUT_W-1:0] drive,
    input logic [DIO_CFG_W-1:0] cfg,
    input logic trig
  );
    logic inv;
    logic [DIO_OUT_W-1:0] sel;
    inv = cfg[DIO_INV_BIT];
    sel = cfg[DIO_TRIG_LSB +: DIO_OUT_W];
    if (halt) begin
      mosfets = {DIO_OUT_W{inv}}; // R6
    end else begin
      // R2 R3 R5 R4
      mosfets = ((drive ^ {DIO_OUT_W{inv}}) & ~sel) | (sel & {DIO_OUT_W{trig}});
    end
  endfunction : mosfets

  // ============================================================
  // Pin synchroniser
  dio_pin_in_t pins_raw;
  dio_pin_in_t pins_sync;

  assign pins_raw = '{pins: in_pins, halt_n: halt_pin_n};

  dio_in_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins_raw(pins_raw),
    .pins_sync(pins_sync)
  );

  // ============================================================
  // Next-state logic
  dio_state_t q;
  dio_state_t next_q;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_wr;
  logic wr_ok;
  logic [DIO_DATA_W-1:0] rd_word;
  logic [DIO_DATA_W-1:0] wr_word;
  logic [DIO_IRQ_W-1:0] ev;

  assign aw_hs = s_axi_awvalid && q.awready;
  assign w_hs = s_axi_wvalid && q.wready;
  assign ar_hs = s_axi_arvalid && q.arready;

  // Read mux; unused bits read as zero
  always_comb begin
    rd_word = '0;
    case (s_axi_araddr)
      DIO_OFS_IN_STATUS: begin
        rd_word[DIO_IN_W-1:0] = pins_sync.pins; // R1
        rd_word[DIO_HALT_BIT] = q.halt;
      end
      DIO_OFS_OUT_DRIVE: rd_word[DIO_OUT_W-1:0] = q.drive;
      DIO_OFS_OUT_CFG: rd_word[DIO_CFG_W-1:0] = q.cfg;
      DIO_OFS_IRQ_STAT: rd_word[DIO_IRQ_W-1:0] = q.irq_stat;
      DIO_OFS_IRQ_MASK: rd_word[DIO_IRQ_W-1:0] = q.irq_mask;
      default: rd_word = '0;
    endcase
  end

  always_comb begin
    next_q = q;
    do_wr = 1'b0;
    wr_ok = 1'b0;
    wr_word = '0;
    ev = '0;
    // Write address and data are taken independently
    if (aw_hs) begin
      next_q.aw_held = 1'b1;
      next_q.awaddr = s_axi_awaddr;
    end
    if (w_hs) begin
      next_q.w_held = 1'b1;
      next_q.wdata = s_axi_wdata;
      next_q.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end
    if (next_q.aw_held && next_q.w_held && !q.bvalid) begin
      do_wr = 1'b1;
      wr_ok = is_mapped(next_q.awaddr);
      next_q.aw_held = 1'b0;
      next_q.w_held = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = wr_ok ? DIO_RESP_OKAY : DIO_RESP_SLVERR;
    end
    if (do_wr && wr_ok) begin
      case (next_q.awaddr)
        DIO_OFS_IN_STATUS: begin
          // Input bits ignore writes; only the halt latch is writable
          wr_word = merge({{(DIO_DATA_W-1){1'b0}}, q.halt} << DIO_HALT_BIT,
                          next_q.wdata, next_q.wstrb); // R1
          next_q.halt = wr_word[DIO_HALT_BIT];
        end
        DIO_OFS_OUT_DRIVE: begin
          wr_word = merge({{(DIO_DATA_W-DIO_OUT_W){1'b0}}, q.drive},
                          next_q.wdata, next_q.wstrb);
          next_q.drive = wr_word[DIO_OUT_W-1:0]; // R2 R3
        end
        DIO_OFS_OUT_CFG: begin
          wr_word = merge({{(DIO_DATA_W-DIO_CFG_W){1'b0}}, q.cfg},
                          next_q.wdata, next_q.wstrb);
          next_q.cfg = wr_word[DIO_CFG_W-1:0] & DIO_CFG_WMASK; // R5
        end
        DIO_OFS_IRQ_STAT: begin
          if (next_q.wstrb[0]) begin
            next_q.irq_stat = q.irq_stat & ~next_q.wdata[DIO_IRQ_W-1:0];
          end
        end
        DIO_OFS_IRQ_MASK: begin
          if (next_q.wstrb[0]) begin
            next_q.irq_mask = next_q.wdata[DIO_IRQ_W-1:0];
          end
        end
        default: next_q.bresp = DIO_RESP_SLVERR;
      endcase
    end
    next_q.awready = !next_q.aw_held && !next_q.bvalid;
    next_q.wready = !next_q.w_held && !next_q.bvalid;

    // Read channel: one outstanding read
    if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end
    if (ar_hs) begin
      next_q.rvalid = 1'b1;
      next_q.rdata = rd_word;
      next_q.rresp = is_mapped(s_axi_araddr) ? DIO_RESP_OKAY : DIO_RESP_SLVERR;
    end
    next_q.arready = !next_q.rvalid;

    // Pin low beats a software clear in the same cycle
    if (!pins_sync.halt_n) begin
      next_q.halt = 1'b1; // R7
      ev[DIO_IRQ_HALT] = !q.halt;
    end
    ev[DIO_IRQ_TRIG] = trig_event;
    next_q.irq_stat = next_q.irq_stat | ev;
    next_q.irq = |(next_q.irq_stat & next_q.irq_mask);

    // Same edge as the register write, so pins change with the B response
    next_q.oe_n = ~mosfets(next_q.halt, next_q.drive, next_q.cfg, trig_event);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= DIO_STATE_RST;
    end else begin
      q <= next_q;
    end
  end

  // ============================================================
  // Outputs
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  // Open drain: the pin is only ever pulled low
  assign out_pin_o = q.pin_level;
  // Enable kept inverted in the register so the pin never glitches
  assign out_pin_oe_n = q.oe_n;
  assign irq = q.irq;

  // ============================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic plain_mode;
  assign plain_mode = !q.halt && (q.cfg[DIO_TRIG_LSB +: DIO_OUT_W] == '0);

  property p_in_status;
    ar_hs && (s_axi_araddr == DIO_OFS_IN_STATUS)
      |=> (s_axi_rdata[DIO_IN_W-1:0] == $past(pins_sync.pins)) && s_axi_rvalid;
  endproperty
  a_in_status: assert property (p_in_status) else $error("input status mismatch"); // R1

  property p_drive_on;
    plain_mode && !q.cfg[DIO_INV_BIT] |-> (out_pin_oe_n & q.drive) == '0;
  endproperty
  a_drive_on: assert property (p_drive_on) else $error("driven bit not on"); // R2

  property p_drive_off;
    plain_mode && !q.cfg[DIO_INV_BIT] |-> (out_pin_oe_n | q.drive) == '1;
  endproperty
  a_drive_off: assert property (p_drive_off) else $error("cleared bit not off"); // R3

  property p_trig_rest;
    !q.halt && q.cfg[DIO_TRIG_LSB] && !$past(trig_event) |-> out_pin_oe_n[0];
  endproperty
  a_trig_rest: assert property (p_trig_rest) else $error("trigger output not resting off"); // R4

  property p_trig_fire;
    !q.halt && q.cfg[DIO_TRIG_LSB] && $past(trig_event) |-> !out_pin_oe_n[0];
  endproperty
  a_trig_fire: assert property (p_trig_fire) else $error("trigger output not on"); // R4

  property p_invert;
    plain_mode && q.cfg[DIO_INV_BIT] |-> out_pin_oe_n == q.drive;
  endproperty
  a_invert: assert property (p_invert) else $error("inverted drive wrong"); // R5

  property p_halt_force;
    q.halt |-> out_pin_oe_n == {DIO_OUT_W{!q.cfg[DIO_INV_BIT]}};
  endproperty
  a_halt_force: assert property (p_halt_force) else $error("halt did not force outputs"); // R6

  property p_halt_pin;
    $fell(halt_pin_n) |-> ##[2:3] q.halt;
  endproperty
  a_halt_pin: assert property (p_halt_pin) else $error("halt pin did not set latch"); // R7

  property p_halt_hold;
    q.halt && !(do_wr && next_q.awaddr == DIO_OFS_IN_STATUS) |=> q.halt;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt latch dropped by itself"); // R7

  c_write: cover property (q.bvalid && s_axi_bready && q.bresp == DIO_RESP_OKAY);
  c_halt: cover property (q.halt ##[1:20] !q.halt);
  c_trig: cover property (q.cfg[DIO_TRIG_LSB] && !out_pin_oe_n[0]);
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (q.bvalid && q.bresp == DIO_RESP_SLVERR);

endmodule : dio_port_ctrl
`default_nettype wire

// ===== testbench/dio_load_model.sv
// Partner model: loads with pull-ups on the outputs, switches on the inputs.
// Assumes out_pin_oe_n low means the output transistor conducts.
`timescale 1ns/1ps
`default_nettype none
module dio_load_model
  import dio_pkg::*;
(
  input wire logic [DIO_OUT_W-1:0] out_pin_o,
  input wire logic [DIO_OUT_W-1:0] out_pin_oe_n,
  input wire logic [DIO_IN_W-1:0] sw_closed,
  output logic [DIO_OUT_W-1:0] pin_level,
  output logic [DIO_IN_W-1:0] in_pins
);
  // Released pin floats up through its pull-up
  always_comb begin
    for (int i = 0; i < DIO_OUT_W; i++) begin
      pin_level[i] = out_pin_oe_n[i] ? 1'b1 : out_pin_o[i];
    end
  end

  // Closed switch grounds its input
  assign in_pins = ~sw_closed;
endmodule : dio_load_model
`default_nettype wire

// ===== testbench/dio_port_ctrl_tb_top.sv
// Self-checking bench for the digital I/O port controller.
// Assumes dio_pkg, a 10 MHz aclk and the load model on the pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module dio_port_ctrl_tb_top
  import dio_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic trig = 1'b0;
  logic halt_n = 1'b1;
  logic [5:0] sw = 6'h00;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic [7:0] out_o, oe_n, pin_lvl;
  logic [5:0] in_pins;
  int n_mismatch = 0;
  int n_compared = 0;

  always #50 aclk = ~aclk;

  dio_port_ctrl DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .in_pins(in_pins),
    .halt_pin_n(halt_n), .trig_event(trig), .out_pin_o(out_o),
    .out_pin_oe_n(oe_n), .irq(irq));

  dio_load_model loads (.out_pin_o(out_o), .out_pin_oe_n(oe_n),
    .sw_closed(sw), .pin_level(pin_lvl), .in_pins(in_pins));

  // ============================================================
  // Reporting
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  // ============================================================
  // Bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
                    input logic [3:0] s = 4'hf);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 40);
    if (bvalid !== 1'b1) begin
      n_mismatch++;
      end_sim();
    end
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 40);
    if (rvalid !== 1'b1) begin
      n_mismatch++;
      end_sim();
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rdr

  // Write, then let the output update settle
  task automatic wrs(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, rs);
    `CHK(rs, DIO_RESP_OKAY);
    @(posedge aclk);
    #1;
  endtask : wrs

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rdr(a, rd, rs);
    `CHK(rd, e);
    `CHK(rs, DIO_RESP_OKAY);
  endtask : rdc

  // ============================================================
  // Scenarios
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    `CHK(oe_n, 8'hff);
    `CHK(pin_lvl, 8'hff);
    for (int i = 1; i < 5; i++) begin
      rdc(8'(i * 4), 32'h0);
    end
    rdc(DIO_OFS_IN_STATUS, 32'h3f);
    @(posedge aclk);
    sw <= 6'h15;
    repeat (3) @(posedge aclk);
    rdc(DIO_OFS_IN_STATUS, 32'h2a);
    wrs(DIO_OFS_IN_STATUS, 32'h3f);
    rdc(DIO_OFS_IN_STATUS, 32'h2a);
    wrs(DIO_OFS_OUT_DRIVE, 32'ha5);
    `CHK(oe_n, 8'h5a);
    `CHK(pin_lvl, 8'h5a);
    `CHK(out_o, 8'h00);
    rdc(DIO_OFS_OUT_DRIVE, 32'ha5);
    wrs(DIO_OFS_OUT_CFG, 32'h20);
    `CHK(oe_n, 8'ha5);
    // Outputs 0 and 1 become trigger outputs
    wrs(DIO_OFS_OUT_CFG, 32'h0320);
    `CHK(oe_n, 8'ha7);
    @(posedge aclk);
    trig <= 1'b1;
    @(posedge aclk);
    #1;
    `CHK(oe_n, 8'ha4);
    @(posedge aclk);
    trig <= 1'b0;
    @(posedge aclk);
    #1;
    `CHK(oe_n, 8'ha7);
    rdc(DIO_OFS_IRQ_STAT, 32'h2);
    wrs(DIO_OFS_IRQ_STAT, 32'h3);
    rdc(DIO_OFS_IRQ_STAT, 32'h0);
    wrs(DIO_OFS_OUT_CFG, 32'h0);
    wrs(DIO_OFS_IRQ_MASK, 32'h1);
    `CHK(irq, 1'b0);
    // Short halt pulse must still latch
    @(posedge aclk);
    halt_n <= 1'b0;
    repeat (2) @(posedge aclk);
    halt_n <= 1'b1;
    repeat (2) @(posedge aclk);
    #1;
    `CHK(oe_n, 8'hff);
    `CHK(irq, 1'b1);
    rdc(DIO_OFS_IN_STATUS, 32'h12a);
    // Lane 1 not strobed: the halt latch must survive
    wr(DIO_OFS_IN_STATUS, 32'h0, rs, 4'h1);
    `CHK(rs, DIO_RESP_OKAY);
    rdc(DIO_OFS_IN_STATUS, 32'h12a);
    wrs(DIO_OFS_OUT_CFG, 32'h20);
    `CHK(oe_n, 8'h00);
    wrs(DIO_OFS_IN_STATUS, 32'h0);
    `CHK(oe_n, 8'ha5);
    rdc(DIO_OFS_IN_STATUS, 32'h2a);
    wrs(DIO_OFS_IRQ_STAT, 32'h1);
    `CHK(irq, 1'b0);
    wr(8'h40, 32'hff, rs);
    `CHK(rs, DIO_RESP_SLVERR);
    rdr(8'h40, rd, rs);
    `CHK(rs, DIO_RESP_SLVERR);
    `CHK(rd, 32'h0);
    // Only upper lanes strobed: drive bits keep their value
    wr(DIO_OFS_OUT_DRIVE, 32'h0, rs, 4'he);
    `CHK(rs, DIO_RESP_OKAY);
    rdc(DIO_OFS_OUT_DRIVE, 32'ha5);
    end_sim();
  end
endmodule : dio_port_ctrl_tb_top
`default_nettype wire
